//--- srct_pkg.sv
// constants and register map of the split reload capture timer
// Summary of operation
// - 16-bit mode: wrap from ffff reloads the counter and sets the high flag
// - 16-bit mode interrupt on full overflow; low-byte wraps too when enabled
// - split mode: two 8-bit counters, each reloads from its own reload byte
// - run control gates only high byte in split mode, whole timer otherwise
// - clock select 1 uses system clock, else divide-by-12, external/8 or real-time/8
// - high flag on high byte wrap; low flag on low byte wrap, any mode
// - split mode interrupt on high overflow, or either byte when enabled
// - hardware never clears the flags; software clears and inspects them
// - capture every 8 selected oscillator cycles copies count to reload, sets high flag
// - capture source 0 is real-time oscillator, 1 is external oscillator
// - external select with low clock select 0: source bit picks count clock
// - external select 0 gives divide-by-12; applies to both bytes in split
// - external oscillator clocks are synchronised before use
// - control register resets to zero, bits flag/flag/len/cen/split/run/src/xclk
// - reload and counter bytes are separate 8-bit registers resetting to zero
package srct_pkg;
  localparam logic [7:0] ADDR_CONTROL     = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h95;
  localparam int BIT_HIGH_FLAG    = 7;
  localparam int BIT_LOW_FLAG     = 6;
  localparam int BIT_LOW_IRQ_EN   = 5;
  localparam int BIT_CAPTURE_EN   = 4;
  localparam int BIT_SPLIT        = 3;
  localparam int BIT_RUN          = 2;
  localparam int BIT_CAPTURE_SRC  = 1;
  localparam int BIT_EXT_CLK_SEL  = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [7:0] BYTE_MAX      = 8'hff;
  localparam logic [3:0] SYS_DIV       = 4'hc;
  localparam logic [3:0] SYS_DIV_LAST  = 4'(SYS_DIV - 4'h1);
  localparam logic [2:0] OSC_DIV_LAST  = 3'h7;
endpackage : srct_pkg

//--- srct_timer.sv
// split reload capture timer: counters, clock sources, capture and sfr port
`timescale 1ns/1ns
module srct_timer
  import srct_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       high_byte_clock_select_i,
  input  wire logic       low_byte_clock_select_i,
  input  wire logic       timer_irq_enable_i,
  input  wire logic       ext_osc_i,
  input  wire logic       rtc_osc_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            irq_o
);
  logic [7:0] ctrl_q;
  logic [7:0] reload_l_q;
  logic [7:0] reload_h_q;
  logic [7:0] cnt_l_q;
  logic [7:0] cnt_h_q;
  logic [3:0] div12_q;
  logic [2:0] ext_sync_q;
  logic [2:0] rtc_sync_q;
  logic       ext_lvl_q;
  logic       rtc_lvl_q;
  logic [2:0] ext_div_q;
  logic [2:0] rtc_div_q;
  logic       ext_rise;
  logic       rtc_rise;
  logic       tick12;
  logic       ext_tick;
  logic       rtc_tick;
  logic       alt_tick;
  logic       cap_tick;
  logic       tick_l;
  logic       tick_h;
  logic       split;
  logic       run;
  logic       inc16;
  logic       inc_l;
  logic       inc_h;
  logic       wrap16;
  logic       ovf_l;
  logic       ovf_h;
  logic       cap_evt;
  logic       wr_ctrl;
  logic       wr_cnt_l;
  logic       wr_cnt_h;

  assign split    = ctrl_q[BIT_SPLIT];
  assign run      = ctrl_q[BIT_RUN];
  assign wr_ctrl  = sfr_wr_i && (sfr_addr_i == ADDR_CONTROL);
  assign wr_cnt_l = sfr_wr_i && (sfr_addr_i == ADDR_COUNT_LOW);
  assign wr_cnt_h = sfr_wr_i && (sfr_addr_i == ADDR_COUNT_HIGH);

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_sync_q <= 3'h0;
      rtc_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
      rtc_lvl_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_sync_q <= {ext_sync_q[1:0], ext_osc_i};
      rtc_sync_q <= {rtc_sync_q[1:0], rtc_osc_i};
      if (ext_sync_q[1] == ext_sync_q[2])
        ext_lvl_q <= ext_sync_q[2];
      if (rtc_sync_q[1] == rtc_sync_q[2])
        rtc_lvl_q <= rtc_sync_q[2];
    end
  end

  assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) && ext_sync_q[2] && !ext_lvl_q;
  assign rtc_rise = (rtc_sync_q[1] == rtc_sync_q[2]) && rtc_sync_q[2] && !rtc_lvl_q;

  // prescalers run free so a mode change never restarts a slow period
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div12_q   <= 4'h0;
      ext_div_q <= 3'h0;
      rtc_div_q <= 3'h0;
    end
    else if (ce_i)
    begin
      div12_q <= (div12_q == SYS_DIV_LAST) ? 4'h0 : div12_q + 4'h1;
      if (ext_rise)
        ext_div_q <= ext_div_q + 3'h1;
      if (rtc_rise)
        rtc_div_q <= rtc_div_q + 3'h1;
    end
  end

  // each source is a single-cycle enable on the system clock
  assign tick12   = ce_i && (div12_q == SYS_DIV_LAST);
  assign ext_tick = ce_i && ext_rise && (ext_div_q == OSC_DIV_LAST);
  assign rtc_tick = ce_i && rtc_rise && (rtc_div_q == OSC_DIV_LAST);
  assign alt_tick = !ctrl_q[BIT_EXT_CLK_SEL] ? tick12 :
                    (ctrl_q[BIT_CAPTURE_SRC] ? rtc_tick : ext_tick);
  assign cap_tick = ctrl_q[BIT_CAPTURE_SRC] ? ext_tick : rtc_tick;
  assign tick_l   = low_byte_clock_select_i ? ce_i : alt_tick;
  assign tick_h   = high_byte_clock_select_i ? ce_i : alt_tick;

  assign inc16  = !split && run && tick_l;
  assign inc_l  = split && tick_l;
  assign inc_h  = split && run && tick_h;
  assign wrap16 = inc16 && ({cnt_h_q, cnt_l_q} == {BYTE_MAX, BYTE_MAX});
  assign ovf_l  = (inc16 || inc_l) && (cnt_l_q == BYTE_MAX);
  assign ovf_h  = wrap16 || (inc_h && (cnt_h_q == BYTE_MAX));
  assign cap_evt = ctrl_q[BIT_CAPTURE_EN] && cap_tick;

  // control: hardware only sets flags, and a set beats a software clear
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_q <= CONTROL_RESET;
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl_q <= sfr_wdata_i;
      if (ovf_h || cap_evt)
        ctrl_q[BIT_HIGH_FLAG] <= 1'b1;
      if (ovf_l)
        ctrl_q[BIT_LOW_FLAG] <= 1'b1;
    end
  end

  // reload bytes; a capture beats a software write in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reload_l_q <= BYTE_RESET;
      reload_h_q <= BYTE_RESET;
    end
    else if (ce_i)
    begin
      if (cap_evt)
      begin
        reload_l_q <= cnt_l_q;
        reload_h_q <= cnt_h_q;
      end
      else if (sfr_wr_i && (sfr_addr_i == ADDR_RELOAD_LOW))
        reload_l_q <= sfr_wdata_i;
      else if (sfr_wr_i && (sfr_addr_i == ADDR_RELOAD_HIGH))
        reload_h_q <= sfr_wdata_i;
    end
  end

  // counter bytes; a software write beats the count in that cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_l_q <= BYTE_RESET;
      cnt_h_q <= BYTE_RESET;
    end
    else if (ce_i)
    begin
      if (wrap16)
        {cnt_h_q, cnt_l_q} <= {reload_h_q, reload_l_q};
      else if (inc16)
        {cnt_h_q, cnt_l_q} <= {cnt_h_q, cnt_l_q} + 16'h0001;
      else
      begin
        if (inc_l)
          cnt_l_q <= (cnt_l_q == BYTE_MAX) ? reload_l_q : cnt_l_q + 8'h01;
        if (inc_h)
          cnt_h_q <= (cnt_h_q == BYTE_MAX) ? reload_h_q : cnt_h_q + 8'h01;
      end
      if (wr_cnt_l)
        cnt_l_q <= sfr_wdata_i;
      if (wr_cnt_h)
        cnt_h_q <= sfr_wdata_i;
    end
  end

  // read data and interrupt request are registered, one cycle behind
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sfr_rdata_o <= 8'h00;
      irq_o       <= 1'b0;
    end
    else if (ce_i)
    begin
      unique case (sfr_addr_i)
        ADDR_CONTROL:     sfr_rdata_o <= ctrl_q;
        ADDR_RELOAD_LOW:  sfr_rdata_o <= reload_l_q;
        ADDR_RELOAD_HIGH: sfr_rdata_o <= reload_h_q;
        ADDR_COUNT_LOW:   sfr_rdata_o <= cnt_l_q;
        ADDR_COUNT_HIGH:  sfr_rdata_o <= cnt_h_q;
        default:          sfr_rdata_o <= 8'h00;
      endcase
      irq_o <= timer_irq_enable_i && (ctrl_q[BIT_HIGH_FLAG] ||
               (ctrl_q[BIT_LOW_IRQ_EN] && ctrl_q[BIT_LOW_FLAG]));
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_wrap_reloads: assert property (ce_i && wrap16 && !wr_cnt_l && !wr_cnt_h
    |=> {cnt_h_q, cnt_l_q} == $past({reload_h_q, reload_l_q}))
    else $error("16-bit wrap did not load the reload value");
  a_high_flag_set: assert property (ce_i && ovf_h |=> ctrl_q[BIT_HIGH_FLAG])
    else $error("high overflow flag not set");
  a_low_flag_set: assert property (ce_i && ovf_l |=> ctrl_q[BIT_LOW_FLAG])
    else $error("low overflow flag not set");
  a_flag_no_hw_clear: assert property (ctrl_q[BIT_HIGH_FLAG] && !(ce_i && wr_ctrl)
    |=> ctrl_q[BIT_HIGH_FLAG])
    else $error("high flag cleared without a write");
  a_capture_copies: assert property (cap_evt |=> {reload_h_q, reload_l_q}
    == $past({cnt_h_q, cnt_l_q}) && ctrl_q[BIT_HIGH_FLAG])
    else $error("capture did not copy the count");
  a_split_high_hold: assert property (ce_i && split && !run && !wr_cnt_h
    |=> $stable(cnt_h_q))
    else $error("high byte moved while stopped in split mode");
  a_stop_holds_16: assert property (ce_i && !split && !run && !wr_cnt_l && !wr_cnt_h
    |=> $stable({cnt_h_q, cnt_l_q}))
    else $error("16-bit timer moved while stopped");
  a_split_low_runs: assert property (ce_i && split && !run && tick_l && !wr_cnt_l
    && cnt_l_q != BYTE_MAX |=> cnt_l_q == $past(cnt_l_q) + 8'h01)
    else $error("low byte did not count in split mode");
  a_div12_spacing: assert property (tick12 |=> !tick12 [*8])
    else $error("divide-by-12 pulses too close");
  a_irq_follows: assert property (ce_i && timer_irq_enable_i && ctrl_q[BIT_HIGH_FLAG]
    |=> irq_o)
    else $error("interrupt not raised for high flag");

  c_wrap16: cover property (ce_i && wrap16);
  c_split_high_ovf: cover property (ce_i && split && ovf_h);
  c_capture: cover property (cap_evt);
endmodule : srct_timer

//--- split_reload_capture_timer_tb_top.sv
// self-checking bench for the split reload capture timer
`timescale 1ns/1ns
module split_reload_capture_timer_tb_top
  import srct_pkg::*;
;
  localparam logic [7:0] REGS [6] = '{8'h90, ADDR_CONTROL, ADDR_RELOAD_LOW,
                                      ADDR_RELOAD_HIGH, ADDR_COUNT_LOW, ADDR_COUNT_HIGH};
  localparam logic [7:0] RATE_CTL [3] = '{8'h04, 8'h05, 8'h07};
  localparam logic [7:0] RATE_N   [3] = '{8'ha0, 8'h0a, 8'h18};
  localparam logic [7:0] CAP_CTL  [2] = '{8'h14, 8'h16};
  localparam logic [7:0] CAP_GAP  [2] = '{8'h50, 8'hc0};
  logic        ref_clk_i   = 1'b0;
  logic        rst_i       = 1'b1;
  logic [7:0]  sfr_addr_i  = 8'h00;
  logic        sfr_wr_i    = 1'b0;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic        hi_sel      = 1'b1;
  logic        lo_sel      = 1'b1;
  logic        irq_en      = 1'b1;
  logic        ce          = 1'b1;
  logic        ext_osc     = 1'b0;
  logic        rtc_osc     = 1'b0;
  logic [7:0]  rdata;
  logic        irq;
  logic [7:0]  v;
  logic [15:0] c0;
  logic [15:0] c1;
  int          errors      = 0;
  int          checked     = 0;

  srct_timer i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .high_byte_clock_select_i(hi_sel), .low_byte_clock_select_i(lo_sel),
    .timer_irq_enable_i(irq_en), .ext_osc_i(ext_osc), .rtc_osc_i(rtc_osc),
    .sfr_rdata_o(rdata), .irq_o(irq));

  initial
  begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // oscillator periods are whole clock multiples so capture gaps come out exact
  initial
  begin
    forever
    begin
      repeat (5) @(posedge ref_clk_i);
      rtc_osc <= ~rtc_osc;
    end
  end
  initial
  begin
    forever
    begin
      repeat (12) @(posedge ref_clk_i);
      ext_osc <= ~ext_osc;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i  <= a;
    sfr_wr_i    <= 1'b1;
    sfr_wdata_i <= d;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    @(posedge ref_clk_i);
    #1 d = rdata;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask : rc
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  // clears the flags, waits for the next capture and returns the captured count
  task automatic cap(input logic [7:0] ctl, output logic [15:0] c);
    int n;
    n = 0;
    wr(ADDR_CONTROL, ctl);
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 400)
    begin
      rd(ADDR_CONTROL, v);
      n++;
    end
    rd(ADDR_RELOAD_LOW, c[7:0]);
    rd(ADDR_RELOAD_HIGH, c[15:8]);
  endtask : cap
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (30000) @(posedge ref_clk_i);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (REGS[i]) rc(REGS[i], 8'h00);
    foreach (REGS[i])
    begin
      wr(REGS[i], {4'h2, 4'(i)});
      rc(REGS[i], (i == 0) ? 8'h00 : {4'h2, 4'(i)});
    end
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    wr(ADDR_COUNT_LOW, 8'hff);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_CONTROL, 8'h04);
    cyc(20);
    rc(ADDR_CONTROL, 8'hc4);
    rc(ADDR_COUNT_HIGH, 8'h12);
    chk({7'h00, irq}, 8'h01);
    @(posedge ref_clk_i);
    irq_en <= 1'b0;
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    @(posedge ref_clk_i);
    irq_en <= 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_COUNT_LOW, c0[7:0]);
    cyc(30);
    rc(ADDR_COUNT_LOW, c0[7:0]);
    wr(ADDR_COUNT_LOW, 8'hff);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h24);
    cyc(5);
    rc(ADDR_CONTROL, 8'h64);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_RELOAD_LOW, 8'ha0);
    wr(ADDR_RELOAD_HIGH, 8'hb0);
    wr(ADDR_COUNT_LOW, 8'hff);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_CONTROL, 8'h08);
    cyc(10);
    rc(ADDR_CONTROL, 8'h48);
    rc(ADDR_COUNT_HIGH, 8'hff);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_COUNT_LOW, v);
    chk(8'(v > 8'ha0 && v < 8'hc0), 8'h01);
    wr(ADDR_CONTROL, 8'h68);
    cyc(3);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_CONTROL, 8'h0c);
    cyc(10);
    rd(ADDR_CONTROL, v);
    chk(v & 8'h80, 8'h80);
    rd(ADDR_COUNT_HIGH, v);
    chk(8'(v > 8'hb0 && v < 8'hc0), 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    foreach (CAP_CTL[i])
    begin
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      cap(CAP_CTL[i], c0);
      cap(CAP_CTL[i], c1);
      chk(8'(c1 - c0), CAP_GAP[i]);
    end
    @(posedge ref_clk_i);
    lo_sel <= 1'b0;
    foreach (RATE_CTL[i])
    begin
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_CONTROL, RATE_CTL[i]);
      cyc(1920);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LOW, v);
      chk(8'(v >= RATE_N[i] - 1 && v <= RATE_N[i] + 1), 8'h01);
    end
    // high byte on the divided clock; a frozen clock enable must not add ticks
    @(posedge ref_clk_i);
    hi_sel <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h0c);
    cyc(1920);
    @(posedge ref_clk_i);
    ce <= 1'b0;
    repeat (600) @(posedge ref_clk_i);
    ce <= 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_HIGH, v);
    chk(8'(v >= 8'h9f && v <= 8'ha1), 8'h01);
    tally_and_finish();
  end
endmodule : split_reload_capture_timer_tb_top
